/* File: hw/pwmg_pkg.sv */
// Package for the four-channel waveform generator: constants and carriers.
// Assumes a single 50 MHz clock and a synchronous active-high reset.
package pwmg_pkg;

  // ****************************************************************
  // Sizes and reset values
  // ****************************************************************
  localparam int          NUM_CH      = 4;        // Generator instances
  localparam int          CNT_W       = 32;       // Period / duration width
  localparam int          RPT_W       = 8;        // Repeat count width
  localparam logic [31:0] PER_RST     = 32'h0000_0000; // Period reset value
  localparam logic [31:0] DUR_RST     = 32'h0000_0000; // Duration reset value
  localparam logic [7:0]  RPT_RST     = 8'h00;    // Repeat reset value

  // ****************************************************************
  // Trigger source selects
  // ****************************************************************
  localparam logic [1:0]  TRG_NONE    = 2'h0;     // Software start only
  localparam logic [1:0]  TRG_PIN     = 2'h1;     // Hardware event pin
  localparam logic [1:0]  TRG_VSYNC   = 2'h2;     // Camera vertical sync

  // ****************************************************************
  // Channel state machine
  // ****************************************************************
  typedef enum logic [1:0] {
    PWMG_IDLE = 2'b00,                             // Output at inactive level
    PWMG_RUN  = 2'b01                              // Generating periods
  } pwmg_state_t;

  // Per-channel software configuration
  typedef struct packed {
    logic              enable;                     // Channel enabled
    logic              oneshot;                    // 1 = one-shot, 0 = continuous
    logic              idle_lvl;                   // Inactive output level
    logic              first_lvl;                  // First-phase output level
    logic [1:0]        trg_sel;                    // Trigger source
    logic              trg_fall;                   // 1 = falling edge starts
    logic [RPT_W-1:0]  repeat_n;                   // Extra periods in a burst
    logic [CNT_W-1:0]  period;                     // Buffered period
    logic [CNT_W-1:0]  duration;                   // Buffered first phase
  } pwmg_cfg_t;

  // Per-channel status and events
  typedef struct packed {
    logic              out;                        // Output pin level
    logic              busy;                       // Channel running
    logic              irq;                        // Period-end pulse to CPU
    logic              dma_evt;                    // Period-end pulse to DMA
  } pwmg_stat_t;

endpackage : pwmg_pkg

/* File: hw/pwmg_chan.sv */
// One waveform generator channel: period counter, duration compare, burst.
// Assumes configuration and trigger are already in the clk domain.
`timescale 1ns/1ns
module pwmg_chan (
  input  wire logic                 clk,      // 50 MHz clock
  input  wire logic                 srst,     // Sync reset
  input  wire pwmg_pkg::pwmg_cfg_t  cfg,      // Configuration
  input  wire logic                 sw_start, // Software start pulse
  input  wire logic                 sw_stop,  // Software stop pulse
  input  wire logic                 trg_lvl,  // Synchronised trigger level
  output pwmg_pkg::pwmg_stat_t      stat      // Status and events
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    pwmg_pkg::pwmg_state_t             st;       // FSM state
    logic [pwmg_pkg::CNT_W-1:0]        cnt;      // Period counter
    logic [pwmg_pkg::CNT_W-1:0]        per;      // Working period
    logic [pwmg_pkg::CNT_W-1:0]        dur;      // Working duration
    logic [pwmg_pkg::RPT_W-1:0]        rpt;      // Periods left after this
    logic                              trg_old;  // Trigger, last cycle
    logic [1:0]                        sel_old;  // Trigger select, last cycle
    pwmg_pkg::pwmg_stat_t              stat;     // Registered outputs
  } pwmg_chan_t;

  pwmg_chan_t s_q;                             // Current state
  pwmg_chan_t s_d;                             // Next state
  logic       edge_hit;                        // Selected trigger edge
  logic       start;                           // Start request
  logic       last_cyc;                        // Last cycle of a period

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb
  begin
    s_d             = s_q;
    s_d.trg_old     = trg_lvl;
    s_d.sel_old     = cfg.trg_sel;
    s_d.stat.irq    = 1'b0;
    s_d.stat.dma_evt = 1'b0;
    // edge select rise/fall
    // A select change swaps the source, not an edge: skip that cycle
    edge_hit = (s_q.sel_old == cfg.trg_sel) &&
               (cfg.trg_fall ? (s_q.trg_old & ~trg_lvl) : (~s_q.trg_old & trg_lvl));
    start    = sw_start | (cfg.oneshot && cfg.trg_sel != pwmg_pkg::TRG_NONE && edge_hit);
    last_cyc = (s_q.cnt >= s_q.per);
    case (s_q.st)
      pwmg_pkg::PWMG_IDLE:
      begin
        s_d.cnt = '0;
        s_d.stat.out = cfg.idle_lvl;
        if (cfg.enable && start)
        begin
          s_d.per  = cfg.period;
          s_d.dur  = cfg.duration;
          s_d.rpt  = cfg.repeat_n;
          s_d.st   = pwmg_pkg::PWMG_RUN;
          s_d.stat.out = (cfg.duration != '0) ? cfg.first_lvl : ~cfg.first_lvl;
        end
      end
      pwmg_pkg::PWMG_RUN:
      begin
        if (last_cyc)
        begin
          s_d.cnt = '0;
          s_d.stat.irq     = 1'b1;
          s_d.stat.dma_evt = 1'b1;
          s_d.per = cfg.period;
          s_d.dur = cfg.duration;
          s_d.stat.out = (cfg.duration != '0) ? cfg.first_lvl : ~cfg.first_lvl;
          if (cfg.oneshot && s_q.rpt == '0)
          begin
            s_d.st       = pwmg_pkg::PWMG_IDLE;
            s_d.stat.out = cfg.idle_lvl;
          end
          else if (cfg.oneshot)
            s_d.rpt = s_q.rpt - 1'b1;
        end
        else
        begin
          s_d.cnt = s_q.cnt + 1'b1;
          s_d.stat.out = (s_q.cnt + 1'b1 < s_q.dur) ? cfg.first_lvl : ~cfg.first_lvl;
        end
        if (sw_stop || !cfg.enable)
        begin
          s_d.st       = pwmg_pkg::PWMG_IDLE;
          s_d.stat.out = cfg.idle_lvl;
        end
      end
      default:
        s_d.st = pwmg_pkg::PWMG_IDLE;
    endcase
    s_d.stat.busy = (s_d.st == pwmg_pkg::PWMG_RUN);
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s_q          <= '0;
      s_q.per      <= pwmg_pkg::PER_RST;
      s_q.dur      <= pwmg_pkg::DUR_RST;
      s_q.rpt      <= pwmg_pkg::RPT_RST;
    end
    else
      s_q <= s_d;
  end

  assign stat = s_q.stat;

endmodule : pwmg_chan

/* File: hw/pwmg_top.sv */
// Top of the waveform generator: four channels and trigger synchronisers.
// Assumes configuration ports are held steady by the clk-domain owner.
`timescale 1ns/1ns
module pwmg_top (
  input  wire logic                                     clk,       // 50 MHz clock
  input  wire logic                                     srst,      // Sync reset
  input  wire pwmg_pkg::pwmg_cfg_t [pwmg_pkg::NUM_CH-1:0] cfg,     // Per-channel config
  input  wire logic [pwmg_pkg::NUM_CH-1:0]              sw_start,  // Software starts
  input  wire logic [pwmg_pkg::NUM_CH-1:0]              sw_stop,   // Software stops
  input  wire logic [pwmg_pkg::NUM_CH-1:0]              evt_pin,   // Event pins, async
  input  wire logic                                     vsync,     // Camera vsync, async
  output logic [pwmg_pkg::NUM_CH-1:0]                   pwm_out,   // Output pins
  output logic [pwmg_pkg::NUM_CH-1:0]                   busy,      // Running flags
  output logic [pwmg_pkg::NUM_CH-1:0]                   irq,       // CPU event pulses
  output logic [pwmg_pkg::NUM_CH-1:0]                   dma_evt    // DMA event pulses
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  typedef struct packed {
    logic [pwmg_pkg::NUM_CH:0] s1;             // First stage
    logic [pwmg_pkg::NUM_CH:0] s2;             // Second stage
  } pwmg_sync_t;

  pwmg_sync_t y_q;                             // Sync state
  pwmg_sync_t y_d;                             // Sync next

  // Two flops per async input
  always_comb
  begin
    y_d    = y_q;
    y_d.s1 = {vsync, evt_pin};
    y_d.s2 = y_q.s1;
  end

  // Sync register, runs through reset to hold the true pin level
  always_ff @(posedge clk)
  begin
    y_q <= y_d;
  end

  // Trigger select decode
  function automatic logic trg_pick(input logic [1:0] sel, input logic pin, input logic vs);
    trg_pick = (sel == pwmg_pkg::TRG_VSYNC) ? vs :
               (sel == pwmg_pkg::TRG_PIN) ? pin : 1'b0;
  endfunction : trg_pick

  // ****************************************************************
  // Channels
  // ****************************************************************
  // four channel instances
  genvar gi;
  generate
    for (gi = 0; gi < pwmg_pkg::NUM_CH; gi++)
    begin : g_ch
      pwmg_pkg::pwmg_stat_t st;              // Channel status
      logic                 trg;             // Chosen trigger
      assign trg = trg_pick(cfg[gi].trg_sel, y_q.s2[gi], y_q.s2[pwmg_pkg::NUM_CH]);
      pwmg_chan u_chan (
        .clk      (clk),
        .srst     (srst),
        .cfg      (cfg[gi]),
        .sw_start (sw_start[gi]),
        .sw_stop  (sw_stop[gi]),
        .trg_lvl  (trg),
        .stat     (st)
      );
      assign pwm_out[gi] = st.out;
      assign busy[gi]    = st.busy;
      assign irq[gi]     = st.irq;
      assign dma_evt[gi] = st.dma_evt;
    end
  endgenerate

endmodule : pwmg_top

/* File: test/pwmg_chk.sv */
// Checker for the four-channel waveform generator top.
// Assumes it is bound to pwmg_top and sees only its ports.
`timescale 1ns/1ns
module pwmg_chk (
  input wire logic                                       clk,
  input wire logic                                       srst,
  input wire pwmg_pkg::pwmg_cfg_t [pwmg_pkg::NUM_CH-1:0] cfg,
  input wire logic [pwmg_pkg::NUM_CH-1:0]                sw_start,
  input wire logic [pwmg_pkg::NUM_CH-1:0]                sw_stop,
  input wire logic [pwmg_pkg::NUM_CH-1:0]                pwm_out,
  input wire logic [pwmg_pkg::NUM_CH-1:0]                busy,
  input wire logic [pwmg_pkg::NUM_CH-1:0]                irq,
  input wire logic [pwmg_pkg::NUM_CH-1:0]                dma_evt
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // ****************************************************************
  // Per-channel properties
  // ****************************************************************
  for (genvar i = 0; i < pwmg_pkg::NUM_CH; i++)
  begin : g_ch
    AST_EVT_PAIR: assert property (irq[i] == dma_evt[i])
      else $error("cpu and dma events differ");
    AST_EVT_RUN: assert property (irq[i] |-> $past(busy[i]))
      else $error("event without a running channel");
    AST_IDLE_LVL: assert property (!busy[i] && !$past(srst) && $stable(cfg[i].idle_lvl)
      |-> pwm_out[i] == cfg[i].idle_lvl) else $error("idle output level wrong");
    AST_FIRST_PH: assert property ($rose(busy[i]) && cfg[i].duration != 0
      |-> pwm_out[i] == cfg[i].first_lvl) else $error("first phase level wrong");
    AST_SW_START: assert property (!busy[i] && sw_start[i] && !sw_stop[i] && cfg[i].enable
      |=> busy[i]) else $error("start not taken");
    AST_SW_STOP: assert property (busy[i] && sw_stop[i]
      |=> !busy[i] && pwm_out[i] == cfg[i].idle_lvl) else $error("stop not taken");
    AST_DISABLE: assert property (!cfg[i].enable |=> !busy[i])
      else $error("disabled channel running");
    AST_CONT_RUN: assert property (busy[i] && !cfg[i].oneshot && cfg[i].enable && !sw_stop[i]
      |=> busy[i]) else $error("continuous run stopped");
    AST_BURST_END: assert property ($fell(busy[i]) && $past(!sw_stop[i] && cfg[i].enable)
      |-> irq[i]) else $error("burst end without event");
  end
endmodule : pwmg_chk

bind pwmg_top pwmg_chk u_pwmg_chk (.clk(clk), .srst(srst), .cfg(cfg), .sw_start(sw_start),
  .sw_stop(sw_stop), .pwm_out(pwm_out), .busy(busy), .irq(irq), .dma_evt(dma_evt));

/* File: test/pwmg_load.sv */
// Load model on the output pins: counts rising edges per channel.
// Assumes clr is a level from the bench in the clk domain.
`timescale 1ns/1ns
module pwmg_load (
  input  wire logic       clk,
  input  wire logic       clr,
  input  wire logic [3:0] pwm_out,
  output int              edges [4]
);
  logic [3:0] last_q; // Pin level one cycle back
  // Edge counter per pin
  always_ff @(posedge clk)
  begin
    last_q <= pwm_out;
    for (int i = 0; i < 4; i++)
      edges[i] <= clr ? 0 : edges[i] + int'(pwm_out[i] && !last_q[i]);
  end
endmodule : pwmg_load

/* File: test/tb.sv */
// Bench for the waveform generator: bursts, continuous, triggers.
// Assumes a 50 MHz clock and the load model on the pins.
`timescale 1ns/1ns
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_total++; \
  $display("mismatch %0t got %0d exp %0d", $time, a, b); end end
module tb;
  logic clk = 0, srst = 1, vsync = 0, clr = 0;
  logic [3:0] sw_start = 0, sw_stop = 0, evt_pin = 0, pwm_out, busy, irq, dma_evt;
  pwmg_pkg::pwmg_cfg_t [3:0] cfg = '0;
  int edges [4];
  int err_total = 0, n_compared = 0;
  always #10 clk = ~clk;
  pwmg_top u_pwmg_top (.clk(clk), .srst(srst), .cfg(cfg), .sw_start(sw_start),
    .sw_stop(sw_stop), .evt_pin(evt_pin), .vsync(vsync), .pwm_out(pwm_out), .busy(busy),
    .irq(irq), .dma_evt(dma_evt));
  pwmg_load u_pwmg_load (.clk(clk), .clr(clr), .pwm_out(pwm_out), .edges(edges));
  function automatic pwmg_pkg::pwmg_cfg_t mk(logic os, fl, il, int p, d, r);
    mk = '0; mk.enable = 1; mk.oneshot = os; mk.first_lvl = fl; mk.idle_lvl = il;
    mk.period = 32'(p); mk.duration = 32'(d); mk.repeat_n = 8'(r);
  endfunction : mk
  // First-phase cycles in one period
  function automatic int fp(pwmg_pkg::pwmg_cfg_t c);
    return (c.duration > c.period) ? int'(c.period) + 1 : int'(c.duration);
  endfunction : fp
  task automatic final_report;
    if (err_total == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  // Burst with optional buffered change after chg busy cycles
  task automatic run(int ch, pwmg_pkg::pwmg_cfg_t c, c2, int chg);
    int nb, nf, ni, nd, r;
    nb = 0; nf = 0; ni = 0; nd = 0; r = int'(c.repeat_n);
    @(posedge clk); cfg[ch] <= c; clr <= 1;
    @(posedge clk); clr <= 0; sw_start[ch] <= 1;
    @(posedge clk); sw_start[ch] <= 0;
    for (int k = 0; k < 4000; k++) begin
      @(negedge clk);
      ni += int'(irq[ch] === 1'b1);
      nd += int'(dma_evt[ch] === 1'b1);
      nb += int'(busy[ch] === 1'b1);
      nf += int'(busy[ch] === 1'b1 && pwm_out[ch] === c.first_lvl);
      if (busy[ch] === 1'b0 && nb > 0) break;
      `CHK(busy & ~(4'h1 << ch), 4'h0)
      @(posedge clk); if (nb == chg) cfg[ch] <= c2;
    end
    if (chg < 0) c2 = c;
    `CHK(nb, int'(c.period) + 1 + r * (int'(c2.period) + 1))
    `CHK(nf, fp(c) + r * fp(c2))
    `CHK(ni, r + 1)
    `CHK(nd, r + 1)
    `CHK(pwm_out[ch], c.idle_lvl)
    if (c.first_lvl && !c.idle_lvl && fp(c) > 0 && fp(c) <= int'(c.period))
      `CHK(edges[ch], r + 1)
  endtask : run
  // Start by a trigger edge from level l0, expect start or not
  task automatic trig(int ch, logic vs, fall, l0, os, exp);
    pwmg_pkg::pwmg_cfg_t c;
    c = mk(os, 1, 0, 40, 5, 0); c.trg_fall = fall;
    c.trg_sel = vs ? pwmg_pkg::TRG_VSYNC : pwmg_pkg::TRG_PIN;
    @(posedge clk); if (vs) vsync <= l0; else evt_pin[ch] <= l0;
    repeat (5) @(posedge clk); cfg[ch] <= c;
    repeat (2) @(posedge clk); if (vs) vsync <= !l0; else evt_pin[ch] <= !l0;
    repeat (8) @(negedge clk);
    `CHK(busy[ch], exp)
    @(posedge clk); cfg[ch].enable <= 0; sw_stop[ch] <= 1;
    @(posedge clk); sw_stop[ch] <= 0;
    @(negedge clk); `CHK(busy[ch], 1'b0)
  endtask : trig
  initial begin
    #400000; err_total++; final_report();
  end
  initial begin
    repeat (5) @(posedge clk); srst <= 0;
    run(0, mk(1, 1, 0, 2, 1, 0), '0, -1);
    run(1, mk(1, 0, 1, 5, 0, 3), '0, -1);
    run(2, mk(1, 1, 1, 3, 9, 2), '0, -1);
    run(3, mk(1, 1, 0, 6, 3, 255), '0, -1);
    run(1, mk(1, 1, 0, 3, 32'h8000_0001, 0), '0, -1);
    run(0, mk(1, 1, 0, 4, 2, 1), mk(1, 1, 0, 6, 4, 1), 2);
    @(posedge clk); cfg[1] <= mk(0, 1, 0, 3, 1, 0); sw_start[1] <= 1;
    @(posedge clk); sw_start[1] <= 0; repeat (30) @(negedge clk);
    `CHK(busy[1], 1'b1)
    @(posedge clk); sw_stop[1] <= 1; @(posedge clk); sw_stop[1] <= 0;
    @(negedge clk); `CHK({busy[1], pwm_out[1]}, 2'b00)
    for (int k = 0; k < 4; k++)
      trig(k, 0, k[1], k[0], 1, k[1] == k[0]);
    trig(2, 1, 0, 0, 1, 1);
    trig(3, 1, 1, 1, 1, 1);
    trig(0, 0, 0, 0, 0, 0);
    final_report();
  end
endmodule : tb
